// file: hdl/lsd_pkg.sv
// Purpose: shared constants, carriers and helpers for the segment display driver
// Assumes: 8-bit data memory, 125 MHz core clock
// Notes:   special register addresses are placed in the special register area
package lsd_pkg;

    localparam int          LSD_NUM_GLYPH      = 28;
    localparam int          LSD_NUM_BACKPLANE  = 4;
    localparam int          LSD_CORE_CLK_HZ    = 125_000_000;

    // display memory window and bank codes
    localparam logic [7:0]  LSD_MEM_FIRST      = 8'h80;
    localparam logic [7:0]  LSD_MEM_LAST       = 8'h9B;
    localparam logic [7:0]  LSD_BANK_DISPLAY   = 8'h01;
    localparam logic [7:0]  LSD_BANK_GENERAL   = 8'h00;

    // special register addresses
    localparam logic [7:0]  LSD_ADDR_CTRL      = 8'h60;
    localparam logic [7:0]  LSD_ADDR_GEN_LOW   = 8'h61;
    localparam logic [7:0]  LSD_ADDR_GEN_MID   = 8'h62;
    localparam logic [7:0]  LSD_ADDR_GEN_HIGH  = 8'h63;
    localparam logic [7:0]  LSD_ADDR_BP_TOP    = 8'h64;

    // display control field positions
    localparam int          LSD_CTRL_EN_BIT    = 7;
    localparam int          LSD_CTRL_TYPE_BIT  = 6;
    localparam int          LSD_CTRL_CUR_LSB   = 0;
    localparam int          LSD_BPEN_LSB       = 4;

    // reset values
    localparam logic [7:0]  LSD_CTRL_RESET     = 8'h00;
    localparam logic [7:0]  LSD_PINEN_RESET    = 8'h00;

    // subclock divider
    localparam int          LSD_SUB_DIV        = 8;
    localparam int          LSD_SUB_HZ         = 32_768;
    localparam int          LSD_DISP_HZ        = LSD_SUB_HZ / LSD_SUB_DIV;
    localparam int          LSD_TICK_MIN_CYC   = LSD_CORE_CLK_HZ / LSD_DISP_HZ;

    typedef struct packed {
        logic       ind_ptr2;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsd_cpu_req_s;

    typedef struct packed {
        logic       enable;
        logic       bias_type;
        logic [1:0] bias_cur;
    } lsd_ctrl_s;

    typedef enum logic [1:0] {
        LSD_PH0 = 2'b00,
        LSD_PH1 = 2'b01,
        LSD_PH2 = 2'b11,
        LSD_PH3 = 2'b10
    } lsd_phase_e;

    typedef enum logic [1:0] {
        LSD_LV_GND       = 2'b00,
        LSD_LV_THIRD     = 2'b01,
        LSD_LV_TWO_THIRD = 2'b10,
        LSD_LV_FULL      = 2'b11
    } lsd_level_e;

    function automatic logic lsd_in_window(input logic [7:0] addr);
        return (addr >= LSD_MEM_FIRST) && (addr <= LSD_MEM_LAST);
    endfunction : lsd_in_window

    function automatic logic [7:0] lsd_ctrl_image(input lsd_ctrl_s c);
        return {c.enable, c.bias_type, 4'h0, c.bias_cur};
    endfunction : lsd_ctrl_image

endpackage : lsd_pkg

// file: hdl/lsd_display_ram.sv
// Purpose: display memory, one byte per glyph pin
// Assumes: write and read indices already range checked
// Notes:   contents are not reset; software must load them
`timescale 1ns/100ps
module lsd_display_ram #(
    parameter int DEPTH = 28
) (
    input  wire logic       core_clk_i,
    input  wire logic       wr_en_i,
    input  wire logic [4:0] wr_idx_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [4:0] rd_idx_i,
    output logic      [7:0] rdata_o,
    input  wire logic [4:0] scan_idx_i,
    output logic      [7:0] scan_data_o
);
    logic [7:0] mem [DEPTH];

    // no reset on purpose, array maps to plain ram cells
    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_idx_i] <= wdata_i;
        end
    end

    assign rdata_o     = mem[rd_idx_i];
    assign scan_data_o = mem[scan_idx_i];

endmodule : lsd_display_ram

// file: hdl/lsd_subclk_div.sv
// Purpose: synchronise the slow oscillators and divide the subclock
// Assumes: both slow oscillators far slower than the core clock
// Notes:   tick_o pulses once per eight subclock rising edges
`timescale 1ns/100ps
module lsd_subclk_div #(
    parameter int DIV = 8
) (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic rc_osc_i,
    input  wire logic xtal_osc_i,
    input  wire logic use_xtal_i,
    output logic      tick_o
);
    logic [1:0] rc_sync_q;
    logic [1:0] xt_sync_q;
    logic       sub_prev_q;
    logic       sub_now;
    logic [$clog2(DIV)-1:0] cnt_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rc_sync_q <= 2'h0;
            xt_sync_q <= 2'h0;
        end else begin
            rc_sync_q <= {rc_sync_q[0], rc_osc_i};
            xt_sync_q <= {xt_sync_q[0], xtal_osc_i};
        end
    end

    // mux after the second stage, first stages feed nothing else
    assign sub_now = use_xtal_i ? xt_sync_q[1] : rc_sync_q[1];

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sub_prev_q <= 1'b0;
            cnt_q      <= '0;
            tick_o     <= 1'b0;
        end else begin
            sub_prev_q <= sub_now;
            tick_o     <= 1'b0;
            if (sub_now && !sub_prev_q) begin
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
                    cnt_q  <= '0;
                    tick_o <= 1'b1;
                end
            end
        end
    end

endmodule : lsd_subclk_div

// file: hdl/lsd_segment_driver.sv
// Purpose: segment display driver, 28 glyph by 4 backplane outputs
// Assumes: core presents each data memory access as one cycle request
// Notes:   levels are 2-bit codes for the analog bias switches
`timescale 1ns/100ps
module lsd_segment_driver
    import lsd_pkg::*;
#(
    parameter int NUM_GLYPH = 28,
    parameter int NUM_BP    = 4
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         slow_internal_rc_osc_i,
    input  wire logic                         slow_crystal_osc_i,
    input  wire logic                         osc_select_strap_i,
    input  wire lsd_pkg::lsd_cpu_req_s        cpu_req_i,
    input  wire logic [7:0]                   bank_select_pointer_i,
    input  wire logic                         sleep_mode_i,
    input  wire logic                         cpu_halted_i,
    output logic                              mem_hit_o,
    output logic                              reg_hit_o,
    output logic      [7:0]                   rdata_o,
    output logic      [NUM_GLYPH-1:0][1:0]    glyph_level_o,
    output logic      [NUM_BP-1:0][1:0]       backplane_level_o,
    output logic      [NUM_GLYPH-1:0]         glyph_drive_en_o,
    output logic      [NUM_BP-1:0]            backplane_drive_en_o,
    output logic      [NUM_GLYPH-1:0]         glyph_pin_enable_o,
    output logic      [NUM_BP-1:0]            backplane_pin_enable_o,
    output logic                              bias_type_select_o,
    output logic      [1:0]                   bias_current_select_o,
    output logic                              bias_power_on_o
);
    import lsd_pkg::*;

    lsd_ctrl_s              ctrl_q;
    logic [7:0]             gen_low_q;
    logic [7:0]             gen_mid_q;
    logic [7:0]             gen_high_q;
    logic [7:0]             bp_top_q;
    logic                   strap_q;
    logic                   strap_taken_q;
    logic                   tick;
    logic                   disp_on;
    logic                   floating;
    lsd_phase_e             phase_q;
    lsd_phase_e             phase_d;
    logic                   pol_q;
    logic [4:0]             scan_idx_q;
    logic [7:0]             scan_data;
    logic [NUM_GLYPH-1:0]   pixel_q;
    logic [4:0]             mem_idx;
    logic [7:0]             mem_rdata;
    logic                   mem_wr;
    logic [7:0]             reg_rdata;

    assign mem_idx   = 5'(cpu_req_i.addr - LSD_MEM_FIRST);
    assign mem_hit_o = cpu_req_i.ind_ptr2
                     && (bank_select_pointer_i == LSD_BANK_DISPLAY)
                     && lsd_in_window(cpu_req_i.addr);
    assign mem_wr    = mem_hit_o && cpu_req_i.wr;

    always_comb begin
        reg_hit_o = 1'b1;
        reg_rdata = 8'h00;
        unique case (cpu_req_i.addr)
            LSD_ADDR_CTRL:     reg_rdata = lsd_ctrl_image(ctrl_q);
            LSD_ADDR_GEN_LOW:  reg_rdata = gen_low_q;
            LSD_ADDR_GEN_MID:  reg_rdata = gen_mid_q;
            LSD_ADDR_GEN_HIGH: reg_rdata = gen_high_q;
            LSD_ADDR_BP_TOP:   reg_rdata = bp_top_q;
            default:           reg_hit_o = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= lsd_ctrl_s'(4'h0);
        end else if (cpu_req_i.wr && cpu_req_i.addr == LSD_ADDR_CTRL) begin
            ctrl_q.enable    <= cpu_req_i.wdata[LSD_CTRL_EN_BIT];
            ctrl_q.bias_type <= cpu_req_i.wdata[LSD_CTRL_TYPE_BIT];
            ctrl_q.bias_cur  <= cpu_req_i.wdata[LSD_CTRL_CUR_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gen_low_q  <= LSD_PINEN_RESET;
            gen_mid_q  <= LSD_PINEN_RESET;
            gen_high_q <= LSD_PINEN_RESET;
            bp_top_q   <= LSD_PINEN_RESET;
        end else if (cpu_req_i.wr) begin
            if (cpu_req_i.addr == LSD_ADDR_GEN_LOW) begin
                gen_low_q <= cpu_req_i.wdata;
            end
            if (cpu_req_i.addr == LSD_ADDR_GEN_MID) begin
                gen_mid_q <= cpu_req_i.wdata;
            end
            if (cpu_req_i.addr == LSD_ADDR_GEN_HIGH) begin
                gen_high_q <= cpu_req_i.wdata;
            end
            if (cpu_req_i.addr == LSD_ADDR_BP_TOP) begin
                bp_top_q <= cpu_req_i.wdata;
            end
        end
    end

    // read data registered, unmapped reads return zero
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (cpu_req_i.rd) begin
            rdata_o <= mem_hit_o ? mem_rdata : reg_rdata;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            strap_q       <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_q       <= osc_select_strap_i;
            strap_taken_q <= 1'b1;
        end
    end

    lsd_subclk_div #(
        .DIV        (LSD_SUB_DIV)
    ) u_div (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .rc_osc_i   (slow_internal_rc_osc_i),
        .xtal_osc_i (slow_crystal_osc_i),
        .use_xtal_i (strap_q),
        .tick_o     (tick)
    );

    lsd_display_ram #(
        .DEPTH       (NUM_GLYPH)
    ) u_ram (
        .core_clk_i  (core_clk_i),
        .wr_en_i     (mem_wr),
        .wr_idx_i    (mem_idx),
        .wdata_i     (cpu_req_i.wdata),
        .rd_idx_i    (mem_idx),
        .rdata_o     (mem_rdata),
        .scan_idx_i  (scan_idx_q),
        .scan_data_o (scan_data)
    );

    assign disp_on = ctrl_q.enable && !sleep_mode_i;

    // free-running memory scan
    // whole pattern refreshed in 28 cycles, far below one display tick
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scan_idx_q <= 5'h0;
            pixel_q    <= '0;
        end else begin
            scan_idx_q <= (scan_idx_q == 5'(NUM_GLYPH - 1)) ? 5'h0 : scan_idx_q + 5'h1;
            // gray phase code back to backplane bit
            pixel_q[scan_idx_q] <= scan_data[{phase_q[1], ^phase_q}];
        end
    end

    always_comb begin
        unique case (phase_q)
            LSD_PH0: phase_d = LSD_PH1;
            LSD_PH1: phase_d = LSD_PH2;
            LSD_PH2: phase_d = LSD_PH3;
            LSD_PH3: phase_d = LSD_PH0;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_q <= LSD_PH0;
            pol_q   <= 1'b0;
        end else if (!disp_on) begin
            phase_q <= LSD_PH0;
            pol_q   <= 1'b0;
        end else if (tick) begin
            phase_q <= phase_d;
            if (phase_q == LSD_PH3) begin
                pol_q <= !pol_q;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            glyph_level_o     <= '0;
            backplane_level_o <= '0;
        end else begin
            for (int b = 0; b < NUM_BP; b++) begin
                if (!disp_on) begin
                    backplane_level_o[b] <= LSD_LV_GND;
                end else if (phase_q == lsd_phase_e'(b ^ (b >> 1))) begin
                    backplane_level_o[b] <= pol_q ? LSD_LV_GND : LSD_LV_FULL;
                end else begin
                    backplane_level_o[b] <= pol_q ? LSD_LV_TWO_THIRD : LSD_LV_THIRD;
                end
            end
            for (int g = 0; g < NUM_GLYPH; g++) begin
                if (!disp_on) begin
                    glyph_level_o[g] <= LSD_LV_GND;
                end else if (pixel_q[g]) begin
                    glyph_level_o[g] <= pol_q ? LSD_LV_FULL : LSD_LV_GND;
                end else begin
                    glyph_level_o[g] <= pol_q ? LSD_LV_THIRD : LSD_LV_TWO_THIRD;
                end
            end
        end
    end

    assign glyph_pin_enable_o     = {bp_top_q[3:0], gen_high_q, gen_mid_q, gen_low_q};
    assign backplane_pin_enable_o = bp_top_q[LSD_BPEN_LSB +: 4];

    // float in halt with capacitor bias while the display is disabled
    assign floating = !ctrl_q.enable && cpu_halted_i && ctrl_q.bias_type;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            glyph_drive_en_o     <= '0;
            backplane_drive_en_o <= '0;
        end else begin
            glyph_drive_en_o     <= floating ? '0 : glyph_pin_enable_o;
            backplane_drive_en_o <= floating ? '0 : backplane_pin_enable_o;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bias_type_select_o    <= 1'b0;
            bias_current_select_o <= 2'h0;
            bias_power_on_o       <= 1'b0;
        end else begin
            bias_type_select_o    <= ctrl_q.bias_type;
            bias_current_select_o <= ctrl_q.bias_cur;
            bias_power_on_o       <= disp_on;
        end
    end

    // assertions
    property p_general_bank;
        @(posedge core_clk_i) disable iff (reset_i)
        (bank_select_pointer_i == LSD_BANK_GENERAL) |-> !mem_hit_o;
    endproperty
    a_general_bank: assert property (p_general_bank)
        else $error("display memory hit with general bank");

    property p_direct_miss;
        @(posedge core_clk_i) disable iff (reset_i)
        !cpu_req_i.ind_ptr2 |-> !mem_hit_o;
    endproperty
    a_direct_miss: assert property (p_direct_miss)
        else $error("direct access reached display memory");

    property p_readback;
        @(posedge core_clk_i) disable iff (reset_i)
        (mem_wr ##2 (cpu_req_i.rd && mem_hit_o && mem_idx == $past(mem_idx, 2) && !mem_wr && !$past(mem_wr)))
        |=> (rdata_o == $past(cpu_req_i.wdata, 3));
    endproperty
    a_readback: assert property (p_readback)
        else $error("display memory write not read back");

    property p_reserved_zero;
        @(posedge core_clk_i) disable iff (reset_i)
        (cpu_req_i.rd && !mem_hit_o && cpu_req_i.addr == LSD_ADDR_CTRL) |=> (rdata_o[5:2] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    property p_reset_clear;
        @(posedge core_clk_i) disable iff (reset_i)
        $past(reset_i) |-> (lsd_ctrl_image(ctrl_q) == LSD_CTRL_RESET && bp_top_q == LSD_PINEN_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control not clear after reset");

    property p_blank_off;
        @(posedge core_clk_i) disable iff (reset_i)
        (!disp_on ##1 !disp_on) |-> (glyph_level_o == '0 && backplane_level_o == '0 && !bias_power_on_o);
    endproperty
    a_blank_off: assert property (p_blank_off)
        else $error("drive present while display off");

    property p_float;
        @(posedge core_clk_i) disable iff (reset_i)
        floating |=> (glyph_drive_en_o == '0 && backplane_drive_en_o == '0);
    endproperty
    a_float: assert property (p_float)
        else $error("pins driven while floating required");

    property p_gpio_pin;
        @(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> ((glyph_drive_en_o & ~$past(glyph_pin_enable_o)) == '0);
    endproperty
    a_gpio_pin: assert property (p_gpio_pin)
        else $error("general I/O pin driven by display");

    property p_frame_invert;
        @(posedge core_clk_i) disable iff (reset_i)
        (tick && disp_on && phase_q == LSD_PH3) |=> (pol_q != $past(pol_q) && phase_q == LSD_PH0);
    endproperty
    a_frame_invert: assert property (p_frame_invert)
        else $error("frame polarity not inverted");

    property p_tick_spacing;
        @(posedge core_clk_i) disable iff (reset_i)
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("display ticks too close");

    property p_active_row;
        @(posedge core_clk_i) disable iff (reset_i)
        (disp_on && $stable(phase_q) && phase_q == LSD_PH0 && $stable(pol_q))
        |=> (backplane_level_o[0] == (pol_q ? LSD_LV_GND : LSD_LV_FULL));
    endproperty
    a_active_row: assert property (p_active_row)
        else $error("active backplane level wrong");

endmodule : lsd_segment_driver

// file: sim/lsd_panel_model.sv
// Purpose: passive four backplane panel seen by the glyph and backplane pins
// Assumes: a cell lights only when it sees the full supply across it
// Notes:   each cell keeps the state last seen while its backplane was active
`timescale 1ns/100ps
module lsd_panel_model (
    input  wire logic             core_clk_i,
    input  wire logic [27:0][1:0] glyph_level_i,
    input  wire logic [3:0][1:0]  backplane_level_i,
    output logic      [27:0][3:0] lit_o
);
    always_ff @(posedge core_clk_i) begin
        for (int b = 0; b < 4; b++) begin
            for (int g = 0; g < 28; g++) begin
                if (backplane_level_i[b] == 2'b11 || backplane_level_i[b] == 2'b00) begin
                    lit_o[g][b] <= ({backplane_level_i[b], glyph_level_i[g]} == 4'b1100) ||
                                   ({backplane_level_i[b], glyph_level_i[g]} == 4'b0011);
                end
            end
        end
    end
endmodule : lsd_panel_model

// file: sim/tb_lsd_segment_driver.sv
// Purpose: self-checking bench for the segment display driver
// Assumes: slow oscillators sped up to 16 (RC) and 32 (crystal) core cycles so frames stay short
// Notes:   read results are queued and checked by the monitor process
`timescale 1ns/100ps
module tb_lsd_segment_driver;
    import lsd_pkg::*;
    logic             core_clk_i, reset_i, halt, sleep, rd_seen, hit, bpon, btype, strap;
    lsd_cpu_req_s     req;
    logic [7:0]       bank, rdata;
    logic [1:0]       bcur;
    logic [27:0][1:0] glev;
    logic [3:0][1:0]  blev;
    logic [27:0]      gden, gpen;
    logic [3:0]       bden, bpen;
    logic [27:0][3:0] lit;
    logic [7:0]       mem [28];
    logic [7:0]       v [4];
    logic [7:0]       expq [$];
    int               err_total, checked, seed, cyc, t0;

    lsd_segment_driver DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .slow_internal_rc_osc_i(cyc[3]),
        .slow_crystal_osc_i(cyc[4]), .osc_select_strap_i(strap), .cpu_req_i(req), .bank_select_pointer_i(bank),
        .sleep_mode_i(sleep), .cpu_halted_i(halt), .mem_hit_o(hit), .reg_hit_o(), .rdata_o(rdata),
        .glyph_level_o(glev), .backplane_level_o(blev), .glyph_drive_en_o(gden), .backplane_drive_en_o(bden),
        .glyph_pin_enable_o(gpen), .backplane_pin_enable_o(bpen), .bias_type_select_o(btype),
        .bias_current_select_o(bcur), .bias_power_on_o(bpon));
    lsd_panel_model PANEL (.core_clk_i(core_clk_i), .glyph_level_i(glev), .backplane_level_i(blev), .lit_o(lit));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask : cmp_byte

    task automatic cmp_vec(input logic [127:0] e, input logic [127:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask : cmp_vec

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // one request, held over its taking edge; hit sampled while it stands
    task automatic op(input logic w, input logic r, input logic p, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1 req = '{ind_ptr2: p, wr: w, rd: r, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1 req = '0;
    endtask : op

    task automatic rd(input logic p, input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        op(1'b0, 1'b1, p, a, 8'h00);
    endtask : rd

    task automatic gap(output int n);
        logic [3:0][1:0] p;
        p = blev;
        n = 0;
        while (blev === p && n < 400) begin
            @(posedge core_clk_i);
            #1 n++;
        end
    endtask : gap

    function automatic logic [127:0] exp_map();
        logic [27:0][3:0] e;
        for (int n = 0; n < 28; n++) e[n] = mem[n][3:0];
        return {16'h0000, e};
    endfunction : exp_map

    // read data lands one cycle after the taking edge
    always @(posedge core_clk_i) begin
        if (rd_seen) cmp_byte(expq.pop_front(), rdata);
        rd_seen <= req.rd;
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        seed = 70282;
        strap = 1'($random(seed));
        {cyc, err_total, checked} = '0;
        {req, bank, halt, sleep, rd_seen} = '0;
        reset_i = 1'b1;
        repeat (8) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        for (int i = 0; i < 5; i++) rd(1'b0, LSD_ADDR_CTRL + 8'(i), 8'h00);
        rd(1'b0, 8'h70, 8'h00);
        op(1'b1, 1'b0, 1'b0, LSD_ADDR_CTRL, 8'hFF);
        rd(1'b0, LSD_ADDR_CTRL, 8'hC3);
        cmp_vec(128'(1), 128'(btype));
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, 1'b0, LSD_ADDR_CTRL, {6'h00, 2'(i)});
            @(posedge core_clk_i);
            #1 cmp_vec(128'(i), 128'(bcur));
            cmp_vec(128'(0), 128'(btype));
        end
        for (int i = 0; i < 4; i++) begin
            v[i] = 8'($random(seed));
            op(1'b1, 1'b0, 1'b0, LSD_ADDR_GEN_LOW + 8'(i), v[i]);
        end
        rd(1'b0, LSD_ADDR_BP_TOP, v[3]);
        cmp_vec(128'({v[3][3:0], v[2], v[1], v[0]}), 128'(gpen));
        cmp_vec(128'(v[3][7:4]), 128'(bpen));
        bank = LSD_BANK_DISPLAY;
        for (int n = 0; n < 28; n++) begin
            mem[n] = 8'($random(seed));
            op(1'b1, 1'b0, 1'b1, LSD_MEM_FIRST + 8'(n), mem[n]);
        end
        rd(1'b1, LSD_MEM_LAST, mem[27]);
        fork
            op(1'b1, 1'b0, 1'b0, LSD_MEM_FIRST, ~mem[0]);
            #10 cmp_vec(128'(0), 128'(hit));
        join
        rd(1'b1, LSD_MEM_FIRST, mem[0]);
        bank = LSD_BANK_GENERAL;
        fork
            op(1'b1, 1'b0, 1'b1, 8'h81, ~mem[1]);
            #10 cmp_vec(128'(0), 128'(hit));
        join
        bank = LSD_BANK_DISPLAY;
        rd(1'b1, 8'h81, mem[1]);
        for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 1'b0, LSD_ADDR_GEN_LOW + 8'(i), 8'hFF);
        op(1'b1, 1'b0, 1'b0, LSD_ADDR_CTRL, 8'h80);
        // first gap is enable, second lands on an arbitrary tick
        gap(t0);
        gap(t0);
        gap(t0);
        cmp_vec(128'(8 * (strap ? 32 : 16)), 128'(t0));
        repeat (1200) @(posedge core_clk_i);
        cmp_vec(exp_map(), {16'h0000, lit});
        mem[5] = ~mem[5];
        op(1'b1, 1'b0, 1'b1, 8'h85, mem[5]);
        repeat (1200) @(posedge core_clk_i);
        cmp_vec(exp_map(), {16'h0000, lit});
        #1 sleep = 1'b1;
        repeat (3) @(posedge core_clk_i);
        cmp_vec(128'(0), {127'(blev), bpon});
        #1 sleep = 1'b0;
        repeat (3) @(posedge core_clk_i);
        cmp_vec(128'(1), 128'(bpon));
        op(1'b1, 1'b0, 1'b0, LSD_ADDR_CTRL, 8'h40);
        halt = 1'b1;
        repeat (3) @(posedge core_clk_i);
        cmp_vec(128'(0), 128'({gden, bden}));
        repeat (3) @(posedge core_clk_i);
        final_report();
    end
endmodule : tb_lsd_segment_driver
